// [src/adc_pkg.sv]
/*
 activity detector, gain control and mixer configuration constants.
 assumes an 8-bit register port with 8-bit addresses from the control interface.
*/
package adc_pkg;
    // register offsets
    localparam logic [7:0] ADC_OFS_DET_CFG1   = 8'h1e;
    localparam logic [7:0] ADC_OFS_DET_CLK    = 8'h20;
    localparam logic [7:0] ADC_OFS_GAIN_EN    = 8'h24;
    localparam logic [7:0] ADC_OFS_MIX_EN     = 8'h2c;
    localparam logic [7:0] ADC_OFS_IRQ_MASK   = 8'h33;
    localparam logic [7:0] ADC_OFS_IRQ_LATCH  = 8'h3b;
    // reset values
    localparam logic [7:0] ADC_RST_DET_CFG1   = 8'h20;
    localparam logic [7:0] ADC_RST_DET_CLK    = 8'h00;
    localparam logic [7:0] ADC_RST_GAIN_EN    = 8'h00;
    localparam logic [7:0] ADC_RST_MIX_EN     = 8'h00;
    localparam logic [7:0] ADC_RST_IRQ_MASK   = 8'h30;
    // writable bits per register; the rest read back as zero
    localparam logic [7:0] ADC_WM_DET_CFG1    = 8'hfa;
    localparam logic [7:0] ADC_WM_DET_CLK     = 8'hf0;
    localparam logic [7:0] ADC_WM_GAIN_EN     = 8'hf0;
    localparam logic [7:0] ADC_WM_MIX_EN      = 8'h70;
    localparam logic [7:0] ADC_WM_IRQ_MASK    = 8'h30;
    // field positions
    localparam int ADC_POLICY_LSB   = 6;
    localparam int ADC_CHSEL_LSB    = 4;
    localparam int ADC_PIN_IRQ_BIT  = 3;
    localparam int ADC_DET_REC_BIT  = 1;
    localparam int ADC_CLKSRC_LSB   = 6;
    localparam int ADC_EXTFREQ_LSB  = 4;
    localparam int ADC_GAIN_LSB     = 4;
    localparam int ADC_MIX_SIDE_BIT = 6;
    localparam int ADC_MIX_CHAN_BIT = 5;
    localparam int ADC_MIX_LOOP_BIT = 4;
    localparam int ADC_UP_BIT       = 5;
    localparam int ADC_DN_BIT       = 4;

    typedef enum logic [1:0] {
        ADC_POL_HOST,
        ADC_POL_AUTO_BOTH,
        ADC_POL_AUTO_UP,
        ADC_POL_RESERVED
    } adc_policy_t;

    typedef enum logic [1:0] {
        ADC_CLK_OSC,
        ADC_CLK_BITCLK,
        ADC_CLK_CTRLPIN,
        ADC_CLK_CUSTOM
    } adc_clock_source_setting_t;
endpackage

// [src/adc_power_seq.sv]
/*
 adc power sequencer: decides when the recording adc is powered.
 assumes host commands and detector events are one-cycle pulses on clk.
*/
`timescale 1ns/100ps
module adc_power_seq (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // policy
    input  wire adc_pkg::adc_policy_t policy,
    // events
    input  wire logic               host_up,
    input  wire logic               host_down,
    input  wire logic               det_up,
    input  wire logic               det_down,
    // state
    output logic                    adc_on
);
    import adc_pkg::*;

    typedef struct packed {
        logic on;
    } adc_seq_st_t;

    adc_seq_st_t st_r;
    adc_seq_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // host commands act in every policy; down wins over up
        if (host_up)
            st_nxt.on = 1'b1;
        if (det_up && (policy == ADC_POL_AUTO_BOTH || policy == ADC_POL_AUTO_UP))
            st_nxt.on = 1'b1;
        if (det_down && policy == ADC_POL_AUTO_BOTH)
            st_nxt.on = 1'b0;
        if (host_down)
            st_nxt.on = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign adc_on = st_r.on;
endmodule

// [src/adc_act_cfg.sv]
/*
 configuration bank for the activity detector, gain control enables and mixers,
 with the detector event latches, masks and the adc power sequencer.
 assumes a synchronous register port on clk: one-cycle wr_en or rd_en, 8-bit address.
*/
// What this block does
// - policy 0: adc power follows only host commands, detector ignored.
// - policy 1: detector up event powers adc on, down event powers off.
// - policy 2: detector powers on, host powers off; code 3 reserved.
// - bits 5-4 pick monitored channel n+1; reset selects channel 3.
// - bit 3 puts interrupts on data-out pin while not recording.
// - bit 1 keeps detection running while recording; else detection idles then.
// - clock cfg bits 7-6 choose oscillator, bit clock, control pin, custom.
// - 0x24 bits 7-4 enable gain control channels 1-4, reset off.
// - 0x2c bits 6,5,4 enable side, channel, loopback mixers, reset off.
// - register 0x1e resets to 0x20.
// - up and down events latch flags that clear once read.
// - up and down events each have a mask, reset masked.
`timescale 1ns/100ps
module adc_act_cfg (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // register port
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    input  wire logic [7:0]            addr,
    input  wire logic [7:0]            wdata,
    output logic      [7:0]            rdata,
    output logic                       rvalid,
    // host power commands
    input  wire logic                  host_power_up,
    input  wire logic                  host_power_down,
    // detector events and recording state
    input  wire logic                  det_up_event,
    input  wire logic                  det_down_event,
    input  wire logic                  recording,
    // detector controls
    output adc_pkg::adc_policy_t       adc_power_policy,
    output logic      [1:0]            monitored_channel_select,
    output logic                       detector_run,
    output adc_pkg::adc_clock_source_setting_t      detector_clock_source,
    output logic      [1:0]            detector_ext_clock_freq,
    output logic                       adc_power_on,
    // data-out pin interrupt
    output logic                       dout_irq_enable,
    output logic                       dout_irq_level,
    // gain control and mixers
    output logic      [3:0]            gain_ctrl_enable,
    output logic                       mix_side_chain_en,
    output logic                       mix_adc_channel_en,
    output logic                       mix_loopback_en
);
    import adc_pkg::*;

    typedef struct packed {
        logic [7:0] det_cfg1;
        logic [7:0] det_clk;
        logic [7:0] gain_en;
        logic [7:0] mix_en;
        logic [7:0] irq_mask;
        logic [7:0] irq_latch;
        logic [7:0] rdata;
        logic       rvalid;
    } adc_cfg_st_t;

    adc_cfg_st_t st_r;
    adc_cfg_st_t st_nxt;

    logic        det_active;
    logic        up_ev;
    logic        dn_ev;
    logic [7:0]  rd_mux;
    logic        latch_read;

    // while recording, detection runs only when enabled
    assign det_active = !recording || st_r.det_cfg1[ADC_DET_REC_BIT];
    assign up_ev      = det_up_event && det_active;
    assign dn_ev      = det_down_event && det_active;

    always_comb begin
        unique case (addr)
            ADC_OFS_DET_CFG1:  rd_mux = st_r.det_cfg1;
            ADC_OFS_DET_CLK:   rd_mux = st_r.det_clk;
            ADC_OFS_GAIN_EN:   rd_mux = st_r.gain_en;
            ADC_OFS_MIX_EN:    rd_mux = st_r.mix_en;
            ADC_OFS_IRQ_MASK:  rd_mux = st_r.irq_mask;
            ADC_OFS_IRQ_LATCH: rd_mux = st_r.irq_latch;
            default:           rd_mux = 8'h00;
        endcase
    end

    assign latch_read = rd_en && (addr == ADC_OFS_IRQ_LATCH);

    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = rd_en;
        if (rd_en)
            st_nxt.rdata = rd_mux;
        if (wr_en) begin
            // only documented writable bits take the write; reserved bits stay at reset
            unique case (addr)
                ADC_OFS_DET_CFG1:
                    st_nxt.det_cfg1 = wdata & ADC_WM_DET_CFG1;
                ADC_OFS_DET_CLK:
                    st_nxt.det_clk = wdata & ADC_WM_DET_CLK;
                ADC_OFS_GAIN_EN:
                    st_nxt.gain_en = wdata & ADC_WM_GAIN_EN;
                ADC_OFS_MIX_EN:
                    st_nxt.mix_en = wdata & ADC_WM_MIX_EN;
                ADC_OFS_IRQ_MASK:
                    st_nxt.irq_mask = wdata & ADC_WM_IRQ_MASK;
                default: ;
            endcase
        end
        // reading the latch clears it; an event in the same cycle survives the clear
        if (latch_read)
            st_nxt.irq_latch = 8'h00;
        if (up_ev)
            st_nxt.irq_latch[ADC_UP_BIT] = 1'b1;
        if (dn_ev)
            st_nxt.irq_latch[ADC_DN_BIT] = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.det_cfg1  <= ADC_RST_DET_CFG1;
            st_r.det_clk   <= ADC_RST_DET_CLK;
            st_r.gain_en   <= ADC_RST_GAIN_EN;
            st_r.mix_en    <= ADC_RST_MIX_EN;
            st_r.irq_mask  <= ADC_RST_IRQ_MASK;
            st_r.irq_latch <= 8'h00;
            st_r.rdata     <= 8'h00;
            st_r.rvalid    <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // power sequencer sees only unmasked-by-recording detector events;
    // masks gate the interrupt indication, not the power action
    adc_power_seq u_seq (
        .clk       (clk),
        .rst       (rst),
        .policy    (adc_policy_t'(st_r.det_cfg1[ADC_POLICY_LSB +: 2])),
        .host_up   (host_power_up),
        .host_down (host_power_down),
        .det_up    (up_ev),
        .det_down  (dn_ev),
        .adc_on    (adc_power_on)
    );

    assign rdata  = st_r.rdata;
    assign rvalid = st_r.rvalid;

    assign adc_power_policy         = adc_policy_t'(st_r.det_cfg1[ADC_POLICY_LSB +: 2]);
    assign monitored_channel_select = st_r.det_cfg1[ADC_CHSEL_LSB +: 2];
    assign detector_run             = det_active;
    assign detector_clock_source    = adc_clock_source_setting_t'(st_r.det_clk[ADC_CLKSRC_LSB +: 2]);
    // frequency code is passed through untouched; the host keeps it legal
    assign detector_ext_clock_freq  = st_r.det_clk[ADC_EXTFREQ_LSB +: 2];

    // pin only carries interrupts while no channel data is recorded
    assign dout_irq_enable = st_r.det_cfg1[ADC_PIN_IRQ_BIT] && !recording;
    assign dout_irq_level  = dout_irq_enable &&
                             ((st_r.irq_latch[ADC_UP_BIT] && !st_r.irq_mask[ADC_UP_BIT]) ||
                              (st_r.irq_latch[ADC_DN_BIT] && !st_r.irq_mask[ADC_DN_BIT]));

    // channel 1 sits in the top bit, so reverse into channel order
    for (genvar gch = 0; gch < 4; gch++) begin : g_gain
        assign gain_ctrl_enable[gch] = st_r.gain_en[ADC_GAIN_LSB+3-gch];
    end
    assign mix_side_chain_en  = st_r.mix_en[ADC_MIX_SIDE_BIT];
    assign mix_adc_channel_en = st_r.mix_en[ADC_MIX_CHAN_BIT];
    assign mix_loopback_en    = st_r.mix_en[ADC_MIX_LOOP_BIT];
endmodule

// [testbench/adc_act_cfg_monitor.sv]
/* concurrent checks on the activity detector config bank.
   assumes one clock domain; bound onto every adc_act_cfg. */
`timescale 1ns/100ps
module adc_act_cfg_monitor (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // register writes
    input wire logic                 wr_en,
    input wire logic [7:0]           addr,
    input wire logic [7:0]           wdata,
    // register reads
    input wire logic                 rd_en,
    input wire logic                 rvalid,
    // power and detector
    input wire logic                 host_power_up,
    input wire logic                 host_power_down,
    input wire logic                 det_up_event,
    input wire logic                 det_down_event,
    input wire logic                 recording,
    input wire adc_pkg::adc_policy_t adc_power_policy,
    input wire logic [1:0]           monitored_channel_select,
    input wire logic                 detector_run,
    input wire logic                 adc_power_on,
    input wire logic                 dout_irq_enable,
    input wire logic [3:0]           gain_ctrl_enable
);
    import adc_pkg::*;
    logic [7:0] wd_q;
    always_ff @(posedge clk) wd_q <= wdata;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_cfg_wr;
        wr_en && addr == ADC_OFS_DET_CFG1;
    endsequence
    // host power-down outranks a detector wake-up
    sequence s_det_up;
        det_up_event && detector_run && !host_power_down && !det_down_event;
    endsequence
    a_reset_defaults: assert property ($fell(rst) |-> adc_power_policy == ADC_POL_HOST
        && monitored_channel_select == 2'h2 && !adc_power_on) else $error("bad state after reset");
    a_chan_sel_write: assert property (s_cfg_wr |=> monitored_channel_select == wd_q[5:4])
        else $error("channel select not taken");
    a_run_recording: assert property (s_cfg_wr ##1 recording |-> detector_run == wd_q[1])
        else $error("detector run wrong while recording");
    a_dout_irq_cfg: assert property (s_cfg_wr ##1 !recording |-> dout_irq_enable == wd_q[3])
        else $error("data-out irq enable wrong");
    a_gain_en_write: assert property (wr_en && addr == ADC_OFS_GAIN_EN |=> gain_ctrl_enable ==
        {wd_q[4], wd_q[5], wd_q[6], wd_q[7]}) else $error("gain enables not taken");
    a_auto_power_up: assert property (s_det_up ##0
        adc_power_policy inside {ADC_POL_AUTO_BOTH, ADC_POL_AUTO_UP} |=> adc_power_on)
        else $error("detector did not power adc");
    a_auto_power_down: assert property (adc_power_policy == ADC_POL_AUTO_BOTH && det_down_event && detector_run
        |=> !adc_power_on) else $error("detector did not power down adc");
    a_host_only_hold: assert property (adc_power_policy == ADC_POL_HOST && !host_power_up && !host_power_down
        |=> $stable(adc_power_on)) else $error("adc power moved without host");
    a_read_valid_pulse: assert property (rvalid == $past(rd_en))
        else $error("read answer not one cycle after request");
endmodule
bind adc_act_cfg adc_act_cfg_monitor u_mon (.clk(clk), .rst(rst), .wr_en(wr_en), .addr(addr), .wdata(wdata),
    .rd_en(rd_en), .rvalid(rvalid),
    .host_power_up(host_power_up), .host_power_down(host_power_down), .det_up_event(det_up_event),
    .det_down_event(det_down_event), .recording(recording), .adc_power_policy(adc_power_policy),
    .monitored_channel_select(monitored_channel_select), .detector_run(detector_run),
    .adc_power_on(adc_power_on), .dout_irq_enable(dout_irq_enable), .gain_ctrl_enable(gain_ctrl_enable));

// [testbench/adc_act_cfg_tb.sv]
/* self-checking bench for the config bank.
   assumes the register port and power timing of the design's hand-over. */
`timescale 1ns/100ps
module adc_act_cfg_tb;
    import adc_pkg::*;
    logic         clk, rst, wr_en, rd_en, rec, rv, run, on, de, dl, ms, mc, ml;
    logic [7:0]   addr, wdata, rdata, v;
    logic [3:0]   ev, gain;
    logic [1:0]   ch, frq;
    logic [14:0]  e;
    adc_policy_t  pol;
    adc_clock_source_setting_t src;
    int           error_cnt, check_count;
    logic [7:0]   shd [256];
    logic [23:0]  rows [13] = '{24'h1e_bf_ba, 24'h1e_85_80, 24'h20_ff_f0, 24'h20_60_60, 24'h20_b0_b0,
        24'h20_0f_00, 24'h24_a0_a0, 24'h24_5f_50, 24'h2c_ff_70, 24'h2c_28_20, 24'h33_ff_30,
        24'h10_ff_00, 24'h3b_ff_00};
    // config, recording, event {hup, hdn, dup, ddn}, expected power
    logic [19:0]  steps [12] = '{20'h00_0_2_0, 20'h00_0_8_1, 20'h00_0_1_1, 20'h00_0_4_0, 20'h40_0_2_1,
        20'h40_0_1_0, 20'h80_0_2_1, 20'h80_0_1_1, 20'h80_0_4_0, 20'h40_1_2_0, 20'h42_1_2_1, 20'h42_1_1_0};
    logic [15:0]  rsv [6] = '{16'h1e20, 16'h2000, 16'h2400, 16'h2c00, 16'h3330, 16'h3b00};
    adc_act_cfg dut (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rvalid(rv), .host_power_up(ev[3]), .host_power_down(ev[2]), .det_up_event(ev[1]),
        .det_down_event(ev[0]), .recording(rec), .adc_power_policy(pol), .monitored_channel_select(ch),
        .detector_run(run), .detector_clock_source(src), .detector_ext_clock_freq(frq), .adc_power_on(on),
        .dout_irq_enable(de), .dout_irq_level(dl), .gain_ctrl_enable(gain), .mix_side_chain_en(ms),
        .mix_adc_channel_en(mc), .mix_loopback_en(ml));
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        check_count++;
        if (s !== x) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // bounded wait: a missing rvalid leaves stale data and shows as a mismatch
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        for (int i = 0; i < 3 && rv !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        v = rdata;
    endtask
    task automatic pulse(input logic [3:0] p);
        @(posedge clk);
        ev <= p;
        @(posedge clk);
        ev <= 4'h0;
        @(posedge clk);
        #1;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        {rst, wr_en, rd_en, rec, ev, addr, wdata} = 24'h80_0000;
        foreach (shd[i]) shd[i] = 8'h00;
        shd[8'h1e] = 8'h20;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk(v, rows[i][7:0]);
            shd[rows[i][23:16]] = rows[i][7:0];
            e = {shd[8'h1e][7:4], shd[8'h20][7:4], shd[8'h24][4], shd[8'h24][5], shd[8'h24][6], shd[8'h24][7],
                shd[8'h2c][6:4]};
            chk({pol, ch, src, frq, gain, ms, mc, ml}, e);
        end
        foreach (steps[i]) begin
            wr(8'h1e, steps[i][19:12]);
            rec <= steps[i][8];
            pulse(steps[i][7:4]);
            chk(on, steps[i][0]);
        end
        wr(8'h1e, 8'h48);
        rec <= 1'b0;
        rd(8'h3b);
        wr(8'h33, 8'h10);
        pulse(4'h2);
        chk({de, dl}, 2'b11);
        rd(8'h3b);
        chk(v, 8'h20);
        rd(8'h3b);
        chk({v, dl}, 9'h000);
        // an event in the very cycle of the clearing read must survive it
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= 8'h3b;
        ev    <= 4'h2;
        @(posedge clk);
        rd_en <= 1'b0;
        ev    <= 4'h0;
        rd(8'h3b);
        chk(v, 8'h20);
        pulse(4'h1);
        chk({de, dl, on}, 3'b100);
        @(posedge clk);
        rec <= 1'b1;
        pulse(4'h8);
        chk({de, on}, 2'b01);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (rsv[i]) begin
            rd(rsv[i][15:8]);
            chk({on, v}, {1'b0, rsv[i][7:0]});
        end
        wrap_up();
    end
endmodule
